// *** hdl/mrlc_pkg.sv ***
// Constants and carrier types of the mute, reset and lamp control block
// Summary of operation
// - A reset closure counts as valid only if held between a quarter second and two seconds and then released.
// - After a stop command in run or stopped mode the block stays latched stopped until a valid manual reset; muted mode ignores the stop command.
// - A lockout returns to stopped only after the fault is gone, the input was cycled and a valid reset follows; a second valid reset then enters run.
// - Muting starts only when both devices of a pair become active within three seconds of each other.
// - There are two muting pairs, each with a sourcing and a sinking input, and at least one full pair is used.
// - The mute lamp output is lit whenever the block is muted and override is inactive.
// - During override the mute lamp output flashes instead of staying steady.
// - The lamp check switch off in both banks selects a monitored lamp, on in both selects a non-monitored output.
// - With a monitored lamp a detected lamp failure is flagged and blocks entry into muting.
// - The two switch banks must match and must not change while running, else the block locks out.
package mrlc_pkg;

	localparam int unsigned CLOCK_HZ          = 40_000_000;
	localparam int unsigned RESET_MIN_MS      = 250;
	localparam int unsigned RESET_MAX_MS      = 2000;
	localparam int unsigned SIMUL_MS          = 3000;
	localparam int unsigned FLASH_HALF_MS     = 250;
	localparam int unsigned RESET_MIN_CYCLES  = (CLOCK_HZ / 1000) * RESET_MIN_MS;
	localparam int unsigned RESET_MAX_CYCLES  = (CLOCK_HZ / 1000) * RESET_MAX_MS;
	localparam int unsigned SIMUL_CYCLES      = (CLOCK_HZ / 1000) * SIMUL_MS;
	localparam int unsigned FLASH_HALF_CYCLES = (CLOCK_HZ / 1000) * FLASH_HALF_MS;
	localparam int unsigned TIMER_WIDTH       = 32;

	typedef enum {
		MRLC_STOPPED,
		MRLC_RUN,
		MRLC_MUTED,
		MRLC_LOCKOUT
	} mrlc_mode_type;

	typedef struct packed {
		logic first_pair_sourcing_input;
		logic first_pair_sinking_input;
		logic second_pair_sourcing_input;
		logic second_pair_sinking_input;
	} mrlc_mute_in_type;

	typedef struct packed {
		logic lamp_check_select_switch_a;
		logic lamp_check_select_switch_b;
	} mrlc_switch_type;

	typedef struct packed {
		logic muted;
		logic stopped;
		logic lockout;
		logic lamp_fault;
		logic reset_accepted;
	} mrlc_status_type;

endpackage : mrlc_pkg

// *** hdl/mrlc_pair_timer.sv ***
// Simultaneity checker for one pair of muting devices
module mrlc_pair_timer #(
	parameter int unsigned WINDOW_CYCLES = mrlc_pkg::SIMUL_CYCLES
) (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic dev_a,
	input  wire logic dev_b,
	output logic      pair_ok
);
	import mrlc_pkg::*;

	initial begin
		if (WINDOW_CYCLES < 1) $error("mrlc_pair_timer: window must be at least one cycle");
	end

	typedef struct packed {
		logic [TIMER_WIDTH-1:0] count;
		logic                   timing;
		logic                   ok;
	} mrlc_pair_state_type;

	mrlc_pair_state_type state;
	mrlc_pair_state_type next_state;

	// ------------------------------------------------------------
	// Pair qualification
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		if (!dev_a && !dev_b) begin
			next_state.timing = 1'b0;
			next_state.ok     = 1'b0;
			next_state.count  = '0;
		end else if (dev_a && dev_b) begin
			// Both rising on one edge counts as simultaneous
			if ((state.timing && state.count < TIMER_WIDTH'(WINDOW_CYCLES)) || (!state.timing && state.count == '0))
				next_state.ok = 1'b1;
			// Mark the pair as used so one device alone cannot restart it
			if (state.count == '0)
				next_state.count = TIMER_WIDTH'(1);
			next_state.timing = 1'b0;
		end else if (!state.ok) begin
			if (!state.timing && state.count == '0) begin
				next_state.timing = 1'b1;
				next_state.count  = TIMER_WIDTH'(1);
			end else if (state.timing) begin
				if (state.count >= TIMER_WIDTH'(WINDOW_CYCLES))
					next_state.timing = 1'b0;
				else
					next_state.count = state.count + TIMER_WIDTH'(1);
			end
		end else begin
			next_state.ok = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst)
			state <= '0;
		else
			state <= next_state;
	end

	assign pair_ok = state.ok;

endmodule : mrlc_pair_timer

// *** hdl/mrlc_control.sv ***
// Top of the mute, reset and lamp control block
module mrlc_control #(
	parameter int unsigned RESET_MIN  = mrlc_pkg::RESET_MIN_CYCLES,
	parameter int unsigned RESET_MAX  = mrlc_pkg::RESET_MAX_CYCLES,
	parameter int unsigned SIMUL      = mrlc_pkg::SIMUL_CYCLES,
	parameter int unsigned FLASH_HALF = mrlc_pkg::FLASH_HALF_CYCLES
) (
	input  wire logic                       clock,
	input  wire logic                       srst,
	input  wire logic                       reset_switch_input,
	input  wire logic                       stop_command,
	input  wire logic                       fault_present,
	input  wire logic                       fault_input_cycled,
	input  wire logic                       override_active,
	input  wire logic                       mute_request,
	input  wire mrlc_pkg::mrlc_mute_in_type mute_in,
	input  wire mrlc_pkg::mrlc_switch_type  switches,
	input  wire logic                       lamp_sense_ok,
	output logic                            muted_indicator_output,
	output logic                            reset_switch_supply,
	output mrlc_pkg::mrlc_status_type       status
);
	import mrlc_pkg::*;

	initial begin
		if (RESET_MIN < 1 || RESET_MAX <= RESET_MIN) $error("mrlc_control: bad reset hold window");
		if (FLASH_HALF < 1) $error("mrlc_control: flash period must be at least one cycle");
	end

	typedef struct packed {
		mrlc_mode_type          mode;
		logic [TIMER_WIDTH-1:0] hold;
		logic                   held;
		logic                   reset_pulse;
		logic [TIMER_WIDTH-1:0] flash_count;
		logic                   flash;
		logic                   lamp;
		logic                   lamp_fault;
		logic                   cycled;
		logic                   sw_captured;
		mrlc_switch_type        sw_ref;
	} mrlc_state_type;

	mrlc_state_type state;
	mrlc_state_type next_state;
	logic           pair1_ok;
	logic           pair2_ok;
	logic           pairs_ok;
	logic           sw_bad;
	logic           monitored;

	// ------------------------------------------------------------
	// Pair timers
	// ------------------------------------------------------------
	// Sourcing and sinking inputs arrive as active-high levels
	mrlc_pair_timer #(.WINDOW_CYCLES(SIMUL)) pair1 (
		.clock   (clock),
		.srst    (srst),
		.dev_a   (mute_in.first_pair_sourcing_input),
		.dev_b   (mute_in.first_pair_sinking_input),
		.pair_ok (pair1_ok)
	);

	mrlc_pair_timer #(.WINDOW_CYCLES(SIMUL)) pair2 (
		.clock   (clock),
		.srst    (srst),
		.dev_a   (mute_in.second_pair_sourcing_input),
		.dev_b   (mute_in.second_pair_sinking_input),
		.pair_ok (pair2_ok)
	);

	// Unused second pair with both inputs inactive does not block the first
	assign pairs_ok = pair1_ok || pair2_ok;

	// ------------------------------------------------------------
	// Configuration check
	// ------------------------------------------------------------
	assign sw_bad    = (switches.lamp_check_select_switch_a != switches.lamp_check_select_switch_b) ||
	                   (state.sw_captured && switches != state.sw_ref);
	assign monitored = !state.sw_ref.lamp_check_select_switch_a;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_state             = state;
		next_state.reset_pulse = 1'b0;
		if (!state.sw_captured) begin
			next_state.sw_captured = 1'b1;
			next_state.sw_ref      = switches;
		end

		// Reset hold timing
		if (reset_switch_input) begin
			if (!state.held) begin
				next_state.held = 1'b1;
				next_state.hold = TIMER_WIDTH'(1);
			end else if (state.hold <= TIMER_WIDTH'(RESET_MAX)) begin
				next_state.hold = state.hold + TIMER_WIDTH'(1);
			end
		end else if (state.held) begin
			next_state.held = 1'b0;
			next_state.hold = '0;
			if (state.hold >= TIMER_WIDTH'(RESET_MIN) && state.hold <= TIMER_WIDTH'(RESET_MAX))
				next_state.reset_pulse = 1'b1;
		end

		// Lamp flash timing
		if (state.flash_count + TIMER_WIDTH'(1) >= TIMER_WIDTH'(FLASH_HALF)) begin
			next_state.flash_count = '0;
			next_state.flash       = !state.flash;
		end else begin
			next_state.flash_count = state.flash_count + TIMER_WIDTH'(1);
		end

		// Lamp failure detection on a monitored lamp while lit
		if (monitored && state.lamp && !lamp_sense_ok)
			next_state.lamp_fault = 1'b1;

		if (fault_input_cycled && !fault_present)
			next_state.cycled = 1'b1;

		case (state.mode)
			MRLC_STOPPED: begin
				if (state.reset_pulse && !stop_command)
					next_state.mode = MRLC_RUN;
			end
			MRLC_RUN: begin
				if (stop_command)
					next_state.mode = MRLC_STOPPED;
				else if (mute_request && pairs_ok && !state.lamp_fault)
					next_state.mode = MRLC_MUTED;
			end
			MRLC_MUTED: begin
				if (!pairs_ok || !mute_request)
					next_state.mode = MRLC_RUN;
			end
			MRLC_LOCKOUT: begin
				if (state.reset_pulse && state.cycled && !fault_present && !sw_bad) begin
					next_state.mode       = MRLC_STOPPED;
					next_state.cycled     = 1'b0;
					next_state.lamp_fault = monitored && state.lamp && !lamp_sense_ok;
				end
			end
			default: begin
				next_state.mode = MRLC_LOCKOUT;
			end
		endcase

		if (state.mode == MRLC_STOPPED && state.reset_pulse && !stop_command && !fault_present)
			next_state.mode = MRLC_RUN;

		if ((fault_present || sw_bad) && state.mode != MRLC_LOCKOUT) begin
			next_state.mode   = MRLC_LOCKOUT;
			next_state.cycled = 1'b0;
		end

		// Lamp drive
		if (override_active)
			next_state.lamp = state.flash;
		else
			next_state.lamp = (next_state.mode == MRLC_MUTED);
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state      <= '0;
			state.mode <= MRLC_STOPPED;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign muted_indicator_output = state.lamp;
	assign reset_switch_supply    = 1'b1;
	assign status.muted           = (state.mode == MRLC_MUTED);
	assign status.stopped         = (state.mode == MRLC_STOPPED);
	assign status.lockout         = (state.mode == MRLC_LOCKOUT);
	assign status.lamp_fault      = state.lamp_fault;
	assign status.reset_accepted  = state.reset_pulse;

endmodule : mrlc_control

// *** tb/mrlc_monitor.sv ***
// Port checker of the mute, reset and lamp control block
module mrlc_monitor #(parameter int unsigned RESET_MIN = 4, parameter int unsigned RESET_MAX = 10) (
	input wire logic                       clock,
	input wire logic                       srst,
	input wire logic                       reset_switch_input,
	input wire logic                       stop_command,
	input wire logic                       fault_present,
	input wire logic                       override_active,
	input wire logic                       mute_request,
	input wire mrlc_pkg::mrlc_mute_in_type mute_in,
	input wire mrlc_pkg::mrlc_switch_type  switches,
	input wire logic                       muted_indicator_output,
	input wire mrlc_pkg::mrlc_status_type  status
);
	timeunit 1ns;
	timeprecision 1ps;
	import mrlc_pkg::*;
	logic [31:0] run;
	logic [31:0] last;
	logic [3:0]  hist;
	logic        mute_ok;
	assign mute_ok = mute_request && !status.lamp_fault && (&mute_in[3:2] || &mute_in[1:0]);
	// Closure length and lamp history
	always_ff @(posedge clock) begin
		run <= (srst || !reset_switch_input) ? 32'h0 : run + 32'h1;
		hist <= {hist[2:0], muted_indicator_output};
		if (!reset_switch_input && run != 32'h0)
			last <= run;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	sequence s_good_release;
		reset_switch_input ##1 (!reset_switch_input && run >= RESET_MIN && run <= RESET_MAX);
	endsequence
	property p_acc_given; s_good_release |-> ##[1:2] status.reset_accepted; endproperty
	a_acc_given: assert property (p_acc_given) else $error("good reset not taken");
	property p_acc_len; status.reset_accepted |-> last >= RESET_MIN && last <= RESET_MAX; endproperty
	a_acc_len: assert property (p_acc_len) else $error("bad reset taken");
	property p_stop; stop_command |-> ##[1:2] (status.stopped || status.lockout); endproperty
	a_stop: assert property (p_stop) else $error("stop not latched");
	property p_fault; fault_present |=> status.lockout; endproperty
	a_fault: assert property (p_fault) else $error("fault without lockout");
	property p_mute; $rose(status.muted) |-> $past(mute_ok); endproperty
	a_mute: assert property (p_mute) else $error("muted without cause");
	property p_lamp; !override_active && !$past(override_active) |-> muted_indicator_output == status.muted; endproperty
	a_lamp: assert property (p_lamp) else $error("lamp differs from muted");
	property p_flash; override_active [*6] |-> hist != 4'h0 && hist != 4'hf; endproperty
	a_flash: assert property (p_flash) else $error("lamp steady in override");
	property p_bank; (^switches) && !$past(srst) |=> status.lockout; endproperty
	a_bank: assert property (p_bank) else $error("bank mismatch without lockout");
endmodule : mrlc_monitor
bind mrlc_control mrlc_monitor #(.RESET_MIN(RESET_MIN), .RESET_MAX(RESET_MAX)) mrlc_monitor_inst (
	.clock, .srst, .reset_switch_input, .stop_command, .fault_present, .override_active,
	.mute_request, .mute_in, .switches, .muted_indicator_output, .status);

// *** tb/mrlc_partner.sv ***
// Model of the reset switch, muting devices and mute lamp
module mrlc_partner (
	input  wire logic                  clock,
	input  wire logic                  lamp_drive,
	output logic                       reset_switch_input,
	output mrlc_pkg::mrlc_mute_in_type mute_in,
	output logic                       lamp_sense_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	import mrlc_pkg::*;
	logic lamp_good = 1'b1;
	initial reset_switch_input = 1'b0;
	initial mute_in = '0;
	assign lamp_sense_ok = lamp_drive & lamp_good;
	task automatic press(input int unsigned n);
		reset_switch_input <= 1'b1;
		repeat (n) @(posedge clock);
		reset_switch_input <= 1'b0;
		@(posedge clock);
	endtask : press
	task automatic actuate(input int unsigned p, input int unsigned gap);
		mute_in[3-2*p] <= 1'b1;
		repeat (gap) @(posedge clock);
		mute_in[2-2*p] <= 1'b1;
	endtask : actuate
	task automatic release_all;
		mute_in <= '0;
	endtask : release_all
endmodule : mrlc_partner

// *** tb/mrlc_control_tb.sv ***
// Self-checking bench of the mute, reset and lamp control block
module mrlc_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mrlc_pkg::*;
	logic clock = 1'b0, srst = 1'b1, stop_command = 1'b0, fault_present = 1'b0, override_active = 1'b0;
	logic fault_input_cycled = 1'b0, mute_request = 1'b1, watch = 1'b0;
	logic reset_switch_input, lamp_sense_ok, muted_indicator_output, reset_switch_supply;
	mrlc_mute_in_type mute_in;
	mrlc_switch_type  switches = '0;
	mrlc_status_type  status, seen, exp_q[$];
	logic [31:0]      seed = 32'h21d0;
	int unsigned      errors = 0, cmp_count = 0, cycles = 0;
	always #12.5 clock = ~clock;
	mrlc_control #(.RESET_MIN(4), .RESET_MAX(10), .SIMUL(8), .FLASH_HALF(2)) mrlc_control_inst (
		.clock, .srst, .reset_switch_input, .stop_command, .fault_present, .fault_input_cycled,
		.override_active, .mute_request, .mute_in, .switches, .lamp_sense_ok,
		.muted_indicator_output, .reset_switch_supply, .status);
	mrlc_partner mrlc_partner_inst (.clock, .lamp_drive(muted_indicator_output), .reset_switch_input,
		.mute_in, .lamp_sense_ok);
	function automatic int unsigned rnd(input int unsigned n);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed % n;
	endfunction : rnd
	task automatic cmp(input string name, input logic [4:0] e, input logic [4:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask : cmp
	task automatic tick(input int unsigned n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic good_press(input logic [4:0] pulse, input logic [4:0] after);
		exp_q.push_back(pulse);
		exp_q.push_back(after);
		mrlc_partner_inst.press(4 + rnd(7));
		tick(3);
	endtask : good_press
	task automatic lock_exit;
		tick(2);
		// Random levels while locked out must not leave lockout
		repeat (2) begin
			fault_present      <= 1'(rnd(2));
			fault_input_cycled <= 1'(rnd(2));
			stop_command       <= 1'(rnd(2));
			override_active    <= 1'(rnd(2));
			mute_request       <= 1'(rnd(2));
			tick(1);
		end
		fault_present      <= 1'b0;
		stop_command       <= 1'b0;
		override_active    <= 1'b0;
		mute_request       <= 1'b1;
		fault_input_cycled <= 1'b1;
		tick(1);
		fault_input_cycled <= 1'b0;
		good_press(5'h05, 5'h08);
		good_press(5'h09, 5'h00);
	endtask : lock_exit
	task automatic give_verdict;
		if (exp_q.size() != 0)
			errors++;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	// Each settled status change takes the oldest expected value
	always @(negedge clock) begin
		if (watch && status !== seen)
			cmp("status", exp_q.size() ? exp_q.pop_front() : ~status, status);
		seen = status;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		tick(2);
		srst <= 1'b0;
		tick(2);
		watch = 1'b1;
		cmp("supply", 5'h01, reset_switch_supply);
		mrlc_partner_inst.press(3);
		mrlc_partner_inst.press(11);
		tick(3);
		good_press(5'h09, 5'h00);
		mrlc_partner_inst.actuate(0, 12);
		tick(4);
		mrlc_partner_inst.release_all();
		tick(1);
		exp_q.push_back(5'h10);
		mrlc_partner_inst.actuate(1, 1 + rnd(6));
		tick(5);
		cmp("lamp", 5'h01, muted_indicator_output);
		override_active <= 1'b1;
		tick(12);
		override_active <= 1'b0;
		tick(2);
		exp_q.push_back(5'h00);
		mute_request <= 1'b0;
		tick(3);
		mrlc_partner_inst.release_all();
		mute_request <= 1'b1;
		exp_q.push_back(5'h08);
		stop_command <= 1'b1;
		tick(1);
		stop_command <= 1'b0;
		tick(3);
		good_press(5'h09, 5'h00);
		exp_q.push_back(5'h04);
		fault_present <= 1'b1;
		tick(1);
		fault_present <= 1'b0;
		lock_exit();
		exp_q.push_back(5'h04);
		switches <= 2'(1 + rnd(2));
		tick(1);
		switches <= 2'h0;
		lock_exit();
		watch = 1'b0;
		mrlc_partner_inst.lamp_good <= 1'b0;
		mrlc_partner_inst.actuate(0, 2);
		tick(8);
		cmp("lamp_fault", 5'h01, status.lamp_fault);
		mrlc_partner_inst.release_all();
		tick(3);
		mrlc_partner_inst.actuate(0, 2);
		tick(6);
		cmp("muted", 5'h00, status.muted);
		mrlc_partner_inst.release_all();
		switches <= 2'h3;
		srst <= 1'b1;
		tick(2);
		srst <= 1'b0;
		tick(2);
		cmp("reset", 5'h08, status);
		mrlc_partner_inst.press(4 + rnd(7));
		tick(3);
		mrlc_partner_inst.actuate(1, 2);
		tick(6);
		cmp("unmonitored", 5'h10, status);
		give_verdict();
	end
endmodule : mrlc_control_tb
